/* File: tcmm_map.sv */
// Host access decoder and connection entry interpreter for the TDM switch.
`timescale 1ns/1ns
//
// Behaviour
// - Address bit 13 selects memory or registers.
// - Control bits 1-0 pick the memory target.
// - Bits 12-8 stream, bits 7-0 channel.
// - Channel range limited by the stream rate.
// - Mode bit zero means normal switched channel.
// - Bits 13-9 source stream, 8-1 source channel.
// - Conversion off ignores the high entry word.
// - Conversion on uses the high word method.
// - Bit 14 picks variable or constant delay.
// - Mode bit one selects a special channel mode.
module tcmm_map (
  input  wire logic                 i_clock,
  input  wire logic                 i_rstn,
  input  wire logic                 i_enable,
  input  wire logic                 i_select,
  input  wire logic                 i_read,
  input  wire logic                 i_write,
  input  wire logic [13:0]          i_addr,
  input  wire logic [15:0]          i_wdata,
  input  wire logic [63:0]          i_stream_rate,
  input  wire logic                 i_look_valid,
  input  wire logic [4:0]           i_look_stream,
  input  wire logic [7:0]           i_look_channel,
  output logic      [15:0]          o_rdata,
  output logic                      o_ack,
  output logic                      o_refused,
  output logic                      o_variable_delay_enable,
  output logic                      o_look_valid,
  output logic                      o_normal,
  output logic                      o_special,
  output logic      [1:0]           o_special_code,
  output logic      [4:0]           o_src_stream,
  output logic      [7:0]           o_src_channel,
  output logic                      o_use_variable,
  output logic                      o_law_enable,
  output logic      [15:0]          o_law_method
);

  // ************************************************************
  // Request decode
  // ************************************************************
  logic                         take;        // A host access is taken this cycle.
  logic                         mem_space;   // The access targets memory space.
  logic [1:0]                   target;      // Target field of the control register.
  logic [4:0]                   stream;      // Stream number from the address.
  logic [7:0]                   channel;     // Channel number from the address.
  logic [1:0]                   rate;        // Rate code of the addressed stream.
  logic                         in_range;    // Channel exists at the stream rate.
  logic                         mem_ok;      // Memory access that is carried out.
  logic                         ctrl_hit;    // Access to the control register.
  logic [2:0]                   bank_we;     // Per-bank write strobes.
  logic [12:0]                  ram_addr;    // Bank address for the host port.
  logic [47:0]                  host_rdata;  // Registered bank words, host port.
  logic [47:0]                  look_rdata;  // Registered bank words, lookup port.
  logic [15:0]                  look_low;    // Low entry word under lookup.
  logic [15:0]                  look_high;   // High entry word under lookup.

  // Registered state and its next values.
  logic [15:0] ctrl,      next_ctrl;      // Control register.
  logic        s1_valid,  next_s1_valid;  // Access in flight, first stage.
  logic        s1_read,   next_s1_read;   // That access is a read.
  logic        s1_mem,    next_s1_mem;    // Its data comes from a bank.
  logic        s1_refuse, next_s1_refuse; // It was refused.
  logic [1:0]  s1_bank,   next_s1_bank;   // Bank that answers.
  logic [15:0] s1_data,   next_s1_data;   // Register-space read value.
  logic        l1_valid,  next_l1_valid;  // Lookup in flight.
  logic [15:0] next_rdata;
  logic        next_ack;
  logic        next_refused;
  logic        next_look_valid;
  logic        next_normal;
  logic        next_special;
  logic [1:0]  next_special_code;
  logic [4:0]  next_src_stream;
  logic [7:0]  next_src_channel;
  logic        next_use_variable;
  logic        next_law_enable;
  logic [15:0] next_law_method;

  // A write wins over a read when both strobes are high.
  assign take      = i_enable && i_select && (i_read || i_write);
  assign mem_space = i_addr[tcmm_pkg::MEM_SEL_BIT];
  assign target    = ctrl[tcmm_pkg::CTRL_TGT_LO +: 2];
  assign stream    = i_addr[tcmm_pkg::STREAM_HI:tcmm_pkg::STREAM_LO];
  assign channel   = i_addr[tcmm_pkg::CHAN_HI:tcmm_pkg::CHAN_LO];
  assign rate      = i_stream_rate[{stream, 1'b0} +: 2];
  assign ram_addr  = {stream, channel};
  assign ctrl_hit  = !mem_space && (i_addr[12:0] == tcmm_pkg::CTRL_OFS);
  assign look_low  = look_rdata[16 +: 16];
  assign look_high = look_rdata[32 +: 16];

  // Channels above the stream's rate do not exist and are refused.
  always_comb begin
    unique case (tcmm_pkg::tcmm_rate_t'(rate))
      tcmm_pkg::RATE_X1: in_range = (channel[7:5] == 3'h0);
      tcmm_pkg::RATE_X2: in_range = (channel[7:6] == 2'h0);
      tcmm_pkg::RATE_X4: in_range = !channel[7];
      tcmm_pkg::RATE_X8: in_range = 1'b1;
    endcase
  end

  // The reserved target code reaches no bank.
  assign mem_ok = mem_space && in_range && (target != tcmm_pkg::TGT_NONE);

  // One strobe per bank, steered by the target field.
  for (genvar b = 0; b < tcmm_pkg::NUM_BANKS; b++) begin : g_we
    assign bank_we[b] = take && i_write && mem_ok && (target == 2'(b));
  end

  // ************************************************************
  // Memory banks
  // ************************************************************
  tcmm_bank_ram u_ram (
    .i_clock      (i_clock),
    .i_rstn       (i_rstn),
    .i_enable     (i_enable),
    .i_host_we    (bank_we),
    .i_host_addr  (ram_addr),
    .i_host_wdata (i_wdata),
    .i_look_addr  ({i_look_stream, i_look_channel}),
    .o_host_rdata (host_rdata),
    .o_look_rdata (look_rdata)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Host answers come two cycles after the request; the first stage waits
  // for the bank read, the second drives the bus outputs.
  always_comb begin
    next_ctrl      = ctrl;
    next_s1_valid  = take;
    next_s1_read   = take && !i_write;
    next_s1_mem    = mem_ok;
    next_s1_refuse = take && mem_space && !mem_ok;
    next_s1_bank   = target;
    next_s1_data   = ctrl_hit ? ctrl : 16'h0000;
    if (take && i_write && ctrl_hit) begin
      next_ctrl = i_wdata & tcmm_pkg::CTRL_MASK;
    end
    next_ack     = s1_valid;
    next_refused = s1_valid && s1_refuse;
    next_rdata   = 16'h0000;
    if (s1_valid && s1_read) begin
      if (s1_mem) begin
        next_rdata = host_rdata[{s1_bank, 4'h0} +: 16];
      end else begin
        next_rdata = s1_data;
      end
    end
    // Entry interpretation, one cycle after the bank read.
    next_l1_valid     = i_enable && i_look_valid;
    next_look_valid   = l1_valid;
    next_normal       = !look_low[tcmm_pkg::MODE_BIT];
    next_special      = look_low[tcmm_pkg::MODE_BIT];
    next_special_code = 2'h0;
    next_src_stream   = 5'h00;
    next_src_channel  = 8'h00;
    next_use_variable = 1'b0;
    if (look_low[tcmm_pkg::MODE_BIT]) begin
      next_special_code = look_low[tcmm_pkg::PCC_HI:tcmm_pkg::PCC_LO];
    end else begin
      next_src_stream   = look_low[tcmm_pkg::SSA_HI:tcmm_pkg::SSA_LO];
      next_src_channel  = look_low[tcmm_pkg::SCA_HI:tcmm_pkg::SCA_LO];
      next_use_variable = look_low[tcmm_pkg::VC_BIT];
    end
    next_law_enable = look_low[tcmm_pkg::LAW_BIT];
    // The high word is masked off so a stale method never leaks through.
    next_law_method = look_low[tcmm_pkg::LAW_BIT] ? look_high : 16'h0000;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Everything holds while the clock enable is low.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl                    <= tcmm_pkg::CTRL_RESET;
      s1_valid                <= 1'b0;
      s1_read                 <= 1'b0;
      s1_mem                  <= 1'b0;
      s1_refuse               <= 1'b0;
      s1_bank                 <= 2'h0;
      s1_data                 <= 16'h0000;
      l1_valid                <= 1'b0;
      o_rdata                 <= 16'h0000;
      o_ack                   <= 1'b0;
      o_refused               <= 1'b0;
      o_variable_delay_enable <= 1'b0;
      o_look_valid            <= 1'b0;
      o_normal                <= 1'b0;
      o_special               <= 1'b0;
      o_special_code          <= 2'h0;
      o_src_stream            <= 5'h00;
      o_src_channel           <= 8'h00;
      o_use_variable          <= 1'b0;
      o_law_enable            <= 1'b0;
      o_law_method            <= 16'h0000;
    end else if (i_enable) begin
      ctrl                    <= next_ctrl;
      s1_valid                <= next_s1_valid;
      s1_read                 <= next_s1_read;
      s1_mem                  <= next_s1_mem;
      s1_refuse               <= next_s1_refuse;
      s1_bank                 <= next_s1_bank;
      s1_data                 <= next_s1_data;
      l1_valid                <= next_l1_valid;
      o_rdata                 <= next_rdata;
      o_ack                   <= next_ack;
      o_refused               <= next_refused;
      o_variable_delay_enable <= next_ctrl[tcmm_pkg::CTRL_VAR_BIT];
      o_look_valid            <= next_look_valid;
      o_normal                <= next_normal;
      o_special               <= next_special;
      o_special_code          <= next_special_code;
      o_src_stream            <= next_src_stream;
      o_src_channel           <= next_src_channel;
      o_use_variable          <= next_use_variable;
      o_law_enable            <= next_law_enable;
      o_law_method            <= next_law_method;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_ctrl_read;
    take && !i_write && ctrl_hit ##1 i_enable;
  endsequence

  sequence s_slow_miss;
    take && mem_space && (rate == 2'h0) && (channel[7:5] != 3'h0) ##1 i_enable;
  endsequence

  sequence s_lookup;
    l1_valid && i_enable;
  endsequence

  a_ctrl_read_back: assert property (s_ctrl_read |=> o_ack && o_rdata == $past(ctrl, 2))
    else $error("control register read returned the wrong value");
  a_target_steer: assert property (take && i_write && mem_ok |-> bank_we == (3'h1 << target))
    else $error("memory write reached the wrong bank");
  // The rate must be looked up by the stream field of the address, not by any other bits.
  a_stream_decode: assert property (take && mem_space && (i_addr[7:5] != 3'h0)
      && (i_stream_rate[{i_addr[12:8], 1'b0} +: 2] == 2'h0) |-> !mem_ok)
    else $error("stream number decoded wrongly");
  a_slow_range: assert property (s_slow_miss |=> o_refused && o_rdata == 16'h0000)
    else $error("out of range channel was not refused");
  a_normal_mode: assert property (s_lookup |=> o_normal == !$past(look_low[0]))
    else $error("normal mode flag mismatches entry");
  a_source_fields: assert property (s_lookup and !look_low[0]
      |=> {o_src_stream, o_src_channel} == $past(look_low[13:1]))
    else $error("source stream or channel mismatches entry");
  a_law_off: assert property (o_look_valid && !o_law_enable |-> o_law_method == 16'h0000)
    else $error("high word leaked with conversion off");
  a_law_on: assert property (s_lookup and look_low[15] |=> o_law_method == $past(look_high))
    else $error("conversion method not taken from high word");
  a_delay_select: assert property (s_lookup and !look_low[0]
      |=> o_use_variable == $past(look_low[14]))
    else $error("delay source select mismatches entry");
  a_special_mode: assert property (s_lookup and look_low[0]
      |=> o_special && !o_normal && o_src_stream == 5'h00)
    else $error("special mode entry not flagged");

endmodule

/* File: tcmm_pkg.sv */
// Shared constants and types for the connection memory map block.
package tcmm_pkg;

  // ************************************************************
  // Bus and memory geometry
  // ************************************************************
  localparam int ADDR_W      = 14;     // Host address width, memory select on top.
  localparam int DATA_W      = 16;     // Host data width.
  localparam int MEM_SEL_BIT = 13;     // High selects memory space, low register space.
  localparam int STREAM_HI   = 12;     // Upper address bit of the stream number.
  localparam int STREAM_LO   = 8;      // Lower address bit of the stream number.
  localparam int CHAN_HI     = 7;      // Upper address bit of the channel number.
  localparam int CHAN_LO     = 0;      // Lower address bit of the channel number.
  localparam int STREAM_W    = 5;      // Stream number width, streams 0 to 31.
  localparam int CHAN_W      = 8;      // Channel number width, channels 0 to 255.
  localparam int RAM_AW      = 13;     // Stream and channel together.
  localparam int RAM_DEPTH   = 8192;   // Words per memory bank.
  localparam int NUM_BANKS   = 3;      // Data memory, low entry word, high entry word.
  localparam int NUM_STREAMS = 32;     // Streams served by the switch.
  localparam int RATE_W      = 2;      // Per-stream rate code width.

  // ************************************************************
  // Control register
  // ************************************************************
  localparam logic [12:0] CTRL_OFS     = 13'h0000; // Offset inside register space.
  localparam int          CTRL_TGT_LO  = 0;        // Access target field, bits 1 to 0.
  localparam int          CTRL_VAR_BIT = 2;        // Variable delay enable.
  localparam logic [15:0] CTRL_MASK    = 16'h0007; // Bits that are kept.
  localparam logic [15:0] CTRL_RESET   = 16'h0000; // Value after reset.

  // ************************************************************
  // Low connection entry word fields
  // ************************************************************
  localparam int MODE_BIT = 0;   // Entry mode bit, zero for normal switching.
  localparam int SCA_LO   = 1;   // Source channel field low bit.
  localparam int SCA_HI   = 8;   // Source channel field high bit.
  localparam int SSA_LO   = 9;   // Source stream field low bit.
  localparam int SSA_HI   = 13;  // Source stream field high bit.
  localparam int VC_BIT   = 14;  // Variable or constant delay select.
  localparam int LAW_BIT  = 15;  // Law conversion enable.
  localparam int PCC_LO   = 1;   // Special mode code low bit.
  localparam int PCC_HI   = 2;   // Special mode code high bit.

  // Memory target chosen by the control register.
  typedef enum logic [1:0] {
    TGT_DATA    = 2'b00,
    TGT_CM_LOW  = 2'b01,
    TGT_CM_HIGH = 2'b10,
    TGT_NONE    = 2'b11
  } tcmm_target_t;

  // Stream rate codes, lowest rate first.
  typedef enum logic [1:0] {
    RATE_X1 = 2'b00,
    RATE_X2 = 2'b01,
    RATE_X4 = 2'b10,
    RATE_X8 = 2'b11
  } tcmm_rate_t;

endpackage

/* File: tcmm_bank_ram.sv */
// Three memory banks with a host port and a lookup read port.
`timescale 1ns/1ns
module tcmm_bank_ram (
  input  wire logic                                  i_clock,
  input  wire logic                                  i_rstn,
  input  wire logic                                  i_enable,
  input  wire logic [tcmm_pkg::NUM_BANKS-1:0]        i_host_we,
  input  wire logic [tcmm_pkg::RAM_AW-1:0]           i_host_addr,
  input  wire logic [tcmm_pkg::DATA_W-1:0]           i_host_wdata,
  input  wire logic [tcmm_pkg::RAM_AW-1:0]           i_look_addr,
  output logic [tcmm_pkg::NUM_BANKS*tcmm_pkg::DATA_W-1:0] o_host_rdata,
  output logic [tcmm_pkg::NUM_BANKS*tcmm_pkg::DATA_W-1:0] o_look_rdata
);

  // ************************************************************
  // One bank per target
  // ************************************************************
  // Reads return the old word when a write hits the same address, which
  // keeps the bank simple enough to map onto a plain synchronous RAM.
  for (genvar b = 0; b < tcmm_pkg::NUM_BANKS; b++) begin : g_bank
    logic [tcmm_pkg::DATA_W-1:0] mem [0:tcmm_pkg::RAM_DEPTH-1]; // Storage, no reset.

    // Host writes, frozen while the clock enable is low.
    always_ff @(posedge i_clock) begin
      if (i_enable && i_host_we[b]) begin
        mem[i_host_addr] <= i_host_wdata;
      end
    end

    // Registered reads on both ports.
    always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
        o_host_rdata[b*tcmm_pkg::DATA_W +: tcmm_pkg::DATA_W] <= 16'h0000;
        o_look_rdata[b*tcmm_pkg::DATA_W +: tcmm_pkg::DATA_W] <= 16'h0000;
      end else if (i_enable) begin
        o_host_rdata[b*tcmm_pkg::DATA_W +: tcmm_pkg::DATA_W] <= mem[i_host_addr];
        o_look_rdata[b*tcmm_pkg::DATA_W +: tcmm_pkg::DATA_W] <= mem[i_look_addr];
      end
    end
  end

endmodule

/* File: tcmm_host_model.sv */
// Behavioural host processor that issues accesses on the parallel memory bus.
`timescale 1ns/1ns
module tcmm_host_model (
  input  wire logic        i_clock,
  input  wire logic        i_ack,
  input  wire logic        i_refused,
  input  wire logic [15:0] i_rdata,
  output logic             o_select,
  output logic             o_read,
  output logic             o_write,
  output logic      [13:0] o_addr,
  output logic      [15:0] o_wdata
);
  int stalls; // Accesses that never got an answer.

  // ************************************************************
  // Idle bus
  // ************************************************************
  // The bus starts idle, so no access can be taken during reset.
  initial begin
    o_select = 1'b0;
    o_read   = 1'b0;
    o_write  = 1'b0;
    o_addr   = 14'h0000;
    o_wdata  = 16'h0000;
    stalls   = 0;
  end

  // One access: the strobe stands for one cycle, because a held strobe is a new access.
  // Released address and data lines show the inverse of the last value, so a late sample cannot hit it.
  task automatic access(input logic wr, input logic [13:0] addr, input logic [15:0] wd,
                        output logic [15:0] rd, output logic rf, output int waited);
    waited = 0;
    rd = 16'h0000;
    rf = 1'b0;
    @(negedge i_clock);
    o_select = 1'b1;
    o_read   = !wr;
    o_write  = wr;
    o_addr   = addr;
    o_wdata  = wd;
    for (int k = 1; k <= 12 && waited == 0; k++) begin
      @(negedge i_clock);
      if (k == 1) begin
        o_select = 1'b0;
        o_read   = 1'b0;
        o_write  = 1'b0;
        o_addr   = ~addr;
        o_wdata  = ~wd;
      end
      if (i_ack === 1'b1) begin
        rd = i_rdata;
        rf = i_refused;
        waited = k;
      end
    end
    if (waited == 0) begin
      stalls++;
    end
  endtask

  // Programs one connection entry in the safe order a careful host keeps.
  task automatic program_entry(input logic [12:0] where, input logic [15:0] hi,
                               input logic [15:0] lo);
    logic [15:0] rd;
    logic        rf;
    int          w;
    access(1'b1, 14'h0000, {13'h0000, lo[14], 2'b10}, rd, rf, w);
    access(1'b1, {1'b1, where}, hi, rd, rf, w);
    access(1'b1, 14'h0000, {13'h0000, lo[14], 2'b01}, rd, rf, w);
    access(1'b1, {1'b1, where}, lo, rd, rf, w);
  endtask
endmodule

/* File: test_tdm_connection_memory_map.sv */
// Self-checking testbench for the connection memory map block.
`timescale 1ns/1ns
module test_tdm_connection_memory_map;
  logic        i_clock, i_rstn, i_enable, i_select, i_read, i_write, i_look_valid;
  logic [13:0] i_addr;
  logic [15:0] i_wdata, o_rdata, o_law_method;
  logic [63:0] i_stream_rate;
  logic [4:0]  i_look_stream, o_src_stream;
  logic [7:0]  i_look_channel, o_src_channel;
  logic        o_ack, o_refused, o_variable_delay_enable, o_look_valid;
  logic        o_normal, o_special, o_use_variable, o_law_enable;
  logic [1:0]  o_special_code;
  int          error_cnt, tests_run;

  tcmm_map tcmm_map_inst (.i_clock(i_clock), .i_rstn(i_rstn), .i_enable(i_enable),
    .i_select(i_select), .i_read(i_read), .i_write(i_write), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_stream_rate(i_stream_rate), .i_look_valid(i_look_valid),
    .i_look_stream(i_look_stream), .i_look_channel(i_look_channel), .o_rdata(o_rdata),
    .o_ack(o_ack), .o_refused(o_refused), .o_variable_delay_enable(o_variable_delay_enable),
    .o_look_valid(o_look_valid), .o_normal(o_normal), .o_special(o_special),
    .o_special_code(o_special_code), .o_src_stream(o_src_stream),
    .o_src_channel(o_src_channel), .o_use_variable(o_use_variable),
    .o_law_enable(o_law_enable), .o_law_method(o_law_method));

  tcmm_host_model tcmm_host_model_inst (.i_clock(i_clock), .i_ack(o_ack),
    .i_refused(o_refused), .i_rdata(o_rdata), .o_select(i_select), .o_read(i_read),
    .o_write(i_write), .o_addr(i_addr), .o_wdata(i_wdata));

  // ************************************************************
  // Clock and shared tasks
  // ************************************************************
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Compares one value; an unknown never passes.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // A bus access that ends the run if the answer never comes.
  task automatic acc(input logic wr, input logic [13:0] a, input logic [15:0] wd,
                     output logic [15:0] rd, output logic rf, output int w);
    tcmm_host_model_inst.access(wr, a, wd, rd, rf, w);
    if (w == 0) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset values, control register fields and memory space decode.
  task automatic s_targets();
    logic [15:0] rd;
    logic        rf;
    int          w;
    check(o_variable_delay_enable, 16'h0000);
    acc(1'b0, 14'h0000, 16'h0000, rd, rf, w);
    check(rd, 16'h0000);
    check(16'(w), 16'h0002);
    for (int t = 0; t < 3; t++) begin
      acc(1'b1, 14'h0000, 16'(t), rd, rf, w);
      acc(1'b1, {1'b1, 5'h03, 8'h05}, 16'hA000 + 16'(t), rd, rf, w);
    end
    acc(1'b1, {1'b1, 5'h04, 8'h05}, 16'h5555, rd, rf, w);
    for (int t = 0; t < 3; t++) begin
      acc(1'b1, 14'h0000, 16'(t), rd, rf, w);
      acc(1'b0, {1'b1, 5'h03, 8'h05}, 16'h0000, rd, rf, w);
      check(rd, 16'hA000 + 16'(t));
    end
    acc(1'b1, 14'h0005, 16'hFFFF, rd, rf, w);
    acc(1'b0, 14'h0005, 16'h0000, rd, rf, w);
    check({rd[14:0], rf}, 16'h0000);
    acc(1'b1, 14'h0000, 16'hFFFF, rd, rf, w);
    acc(1'b0, 14'h0000, 16'h0000, rd, rf, w);
    check(rd, 16'h0007);
    check(o_variable_delay_enable, 16'h0001);
    acc(1'b0, {1'b1, 5'h03, 8'h05}, 16'h0000, rd, rf, w);
    check({rd[14:0], rf}, 16'h0001);
  endtask

  // Channel limits of each stream rate: just inside for all four, just outside for the lower three only.
  task automatic s_range();
    logic [15:0] rd;
    logic        rf;
    int          w;
    logic [7:0]  lim;
    acc(1'b1, 14'h0000, 16'h0001, rd, rf, w);
    for (int n = 0; n < 4; n++) begin
      lim = 8'((32 << n) - 1);
      acc(1'b1, {1'b1, 5'(n), lim}, 16'h0C00 + 16'(n), rd, rf, w);
      check(rf, 16'h0000);
      acc(1'b0, {1'b1, 5'(n), lim}, 16'h0000, rd, rf, w);
      check(rd, 16'h0C00 + 16'(n));
      if (n < 3) begin
        acc(1'b0, {1'b1, 5'(n), lim + 8'h01}, 16'h0000, rd, rf, w);
        check({rd[14:0], rf}, 16'h0001);
      end
    end
  endtask

  // Programs an entry, looks it up and checks every decoded field.
  task automatic s_entry(input logic [15:0] lo, input logic [15:0] hi);
    int n;
    tcmm_host_model_inst.program_entry({5'h03, 8'hC8}, hi, lo);
    check(16'(tcmm_host_model_inst.stalls), 16'h0000);
    @(negedge i_clock);
    i_look_valid = 1'b1;
    i_look_stream = 5'h03;
    i_look_channel = 8'hC8;
    @(negedge i_clock);
    i_look_valid = 1'b0;
    i_look_stream = 5'h1C;
    i_look_channel = 8'h37;
    n = 1;
    while (o_look_valid !== 1'b1 && n < 10) begin
      @(negedge i_clock);
      n++;
    end
    // A lookup that never answers ends the run rather than checking stale fields.
    if (o_look_valid !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    check(16'(n), 16'h0002);
    check(o_normal, !lo[0]);
    check({o_special, o_special_code}, lo[0] ? {1'b1, lo[2:1]} : 3'b000);
    check(o_src_stream, lo[0] ? 5'h00 : lo[13:9]);
    check(o_src_channel, lo[0] ? 8'h00 : lo[8:1]);
    check(o_use_variable, lo[0] ? 1'b0 : lo[14]);
    check(o_law_enable, lo[15]);
    check(o_law_method, lo[15] ? hi : 16'h0000);
  endtask

  // A stalled clock enable stretches the answer by the stalled cycles.
  task automatic s_enable();
    logic [15:0] rd;
    logic        rf;
    int          w;
    fork
      acc(1'b0, 14'h0000, 16'h0000, rd, rf, w);
      begin
        @(negedge i_clock);
        @(negedge i_clock);
        i_enable = 1'b0;
        repeat (3) @(negedge i_clock);
        i_enable = 1'b1;
      end
    join
    check(16'(w), 16'h0005);
    check(rd, 16'h0001);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    error_cnt = 0;
    tests_run = 0;
    i_rstn = 1'b0;
    i_enable = 1'b1;
    i_look_valid = 1'b0;
    i_look_stream = 5'h00;
    i_look_channel = 8'h00;
    i_stream_rate = 64'h0000_0000_0000_00E4;
    repeat (20) @(negedge i_clock);
    i_rstn = 1'b1;
    check(o_ack, 16'h0000);
    s_targets();
    s_range();
    s_entry({1'b0, 1'b1, 5'h15, 8'hA7, 1'b0}, 16'h1234);
    check(o_variable_delay_enable, 16'h0001);
    s_entry({1'b1, 1'b0, 5'h0A, 8'h3C, 1'b0}, 16'h4321);
    for (int p = 0; p < 4; p++) begin
      s_entry({1'b1, 12'h000, 2'(p), 1'b1}, 16'h00F0);
    end
    s_enable();
    tally_and_finish();
  end
endmodule
